// ==== verilog/multi_port_switch_pkg.sv ====
/*
  Shared constants for the four-master, three-slave crossbar switch:
  port counts, port numbers, address decode and arbitration priorities.
  Assumes one synchronous system clock domain.
*/
package multi_port_switch_pkg;

  localparam int NUM_MASTERS = 4;
  localparam int NUM_SLAVES  = 3;
  localparam int MIDX_W      = 2;
  localparam int SIDX_W      = 2;
  localparam int PRIO_W      = 2;

  // master port numbers
  localparam logic [MIDX_W-1:0] M_CPU_INSTR = 2'h0;
  localparam logic [MIDX_W-1:0] M_CPU_DATA  = 2'h1;
  localparam logic [MIDX_W-1:0] M_DMA       = 2'h2;
  localparam logic [MIDX_W-1:0] M_NET       = 2'h3;

  // slave port numbers
  localparam logic [SIDX_W-1:0] S_FLASH  = 2'h0;
  localparam logic [SIDX_W-1:0] S_SRAM   = 2'h1;
  localparam logic [SIDX_W-1:0] S_BRIDGE = 2'h2;

  // decode on the top two address bits: 00 flash, 01 sram, 1x bridge
  localparam int              DEC_MSB     = 31;
  localparam int              DEC_LSB     = 30;
  localparam logic [1:0]      DEC_FLASH   = 2'h0;
  localparam logic [1:0]      DEC_SRAM    = 2'h1;

  // larger value wins; both cpu ports tie, both bulk movers tie
  localparam logic [PRIO_W-1:0] PRIO_FIXED [NUM_MASTERS] = '{2'h2, 2'h2, 2'h1, 2'h1};
  localparam logic [PRIO_W-1:0] PRIO_ELEV   = 2'h3;

endpackage

// ==== verilog/multi_port_switch.sv ====
/*
  Crossbar switch: four master ports routed to three slave ports with a
  per-slave arbiter (fixed priority, elevation, round-robin on ties).
  Assumes masters hold request, address and write data stable until the
  last beat completes, and slaves answer each beat with s_ready.
*/
`timescale 1ns/1ps
module multi_port_switch
  import multi_port_switch_pkg::*;
#(
  parameter int AW = 32,
  parameter int DW = 32
) (
  input  wire logic                          mclk,      // system clock, 40 MHz
  input  wire logic                          rst,       // async reset, active high
  input  wire logic [NUM_MASTERS-1:0]        m_req,     // master wants a transfer
  input  wire logic [NUM_MASTERS-1:0][AW-1:0] m_addr,   // master address
  input  wire logic [NUM_MASTERS-1:0]        m_we,      // master write
  input  wire logic [NUM_MASTERS-1:0][DW-1:0] m_wdata,  // master write data
  input  wire logic [NUM_MASTERS-1:0]        m_last,    // current beat ends transaction
  input  wire logic [NUM_MASTERS-1:0]        m_elevate, // raise master priority
  output logic      [NUM_MASTERS-1:0]        m_gnt,     // master owns its target slave
  output logic      [NUM_MASTERS-1:0]        m_ready,   // beat completes
  output logic      [NUM_MASTERS-1:0][DW-1:0] m_rdata,  // read data to master
  output logic      [NUM_SLAVES-1:0]         s_sel,     // slave beat active
  output logic      [NUM_SLAVES-1:0][AW-1:0] s_addr,    // slave address
  output logic      [NUM_SLAVES-1:0]         s_we,      // slave write
  output logic      [NUM_SLAVES-1:0][DW-1:0] s_wdata,   // slave write data
  input  wire logic [NUM_SLAVES-1:0]         s_ready,   // slave beat done
  input  wire logic [NUM_SLAVES-1:0][DW-1:0] s_rdata    // slave read data
);

  typedef logic [NUM_MASTERS-1:0][PRIO_W-1:0] prio_vec_t;

  function automatic logic [SIDX_W-1:0] slave_of(input logic [AW-1:0] a);
    if (a[DEC_MSB:DEC_LSB] == DEC_FLASH) begin
      return S_FLASH;
    end else if (a[DEC_MSB:DEC_LSB] == DEC_SRAM) begin
      return S_SRAM;
    end else begin
      return S_BRIDGE;
    end
  endfunction

  // scan starts one past the last winner; strict compare keeps the first tie
  function automatic logic [MIDX_W-1:0] pick(input logic [NUM_MASTERS-1:0] cand,
                                             input logic [MIDX_W-1:0]      last,
                                             input prio_vec_t              pr);
    logic [MIDX_W-1:0] idx;
    logic [MIDX_W-1:0] win;
    logic              found;
    win   = last;
    found = 1'b0;
    for (int k = 1; k <= NUM_MASTERS; k++) begin
      idx = last + k[MIDX_W-1:0];
      if (cand[idx] && (!found || pr[idx] > pr[win])) begin
        win   = idx;
        found = 1'b1;
      end
    end
    return win;
  endfunction

  logic      [NUM_SLAVES-1:0]              busy_q, busy_d;
  logic      [NUM_SLAVES-1:0][MIDX_W-1:0]  owner_q, owner_d;
  logic      [NUM_SLAVES-1:0][MIDX_W-1:0]  last_q, last_d;
  logic      [NUM_SLAVES-1:0][NUM_MASTERS-1:0] cand_c;
  logic      [NUM_MASTERS-1:0][SIDX_W-1:0] tgt_c;
  prio_vec_t                               prio_c;

  always_comb begin
    for (int m = 0; m < NUM_MASTERS; m++) begin
      tgt_c[m]  = slave_of(m_addr[m]);
      prio_c[m] = m_elevate[m] ? PRIO_ELEV : PRIO_FIXED[m];
    end
  end

  function automatic logic is_fetch(input int s, input logic [MIDX_W-1:0] m);
    return (s == int'(S_FLASH)) && (m == M_CPU_INSTR);
  endfunction

  always_comb begin
    logic                   gen;
    logic [NUM_MASTERS-1:0] owned;
    logic [NUM_MASTERS-1:0] allow;
    logic [MIDX_W-1:0]      w;
    busy_d  = busy_q;
    owner_d = owner_q;
    last_d  = last_q;
    cand_c  = '0;
    gen     = 1'b0;
    owned   = '0;
    allow   = '0;
    w       = '0;
    for (int s = 0; s < NUM_SLAVES; s++) begin
      if (busy_q[s]) begin
        owned[owner_q[s]] = 1'b1;
        if (!is_fetch(s, owner_q[s])) begin
          gen = 1'b1;
        end
      end
    end
    for (int s = 0; s < NUM_SLAVES; s++) begin
      if (busy_q[s]) begin
        // ownership only ends on the owner's last completed beat
        if (s_ready[s] && m_req[owner_q[s]] && m_last[owner_q[s]]) begin
          busy_d[s] = 1'b0;
        end
      end else begin
        for (int m = 0; m < NUM_MASTERS; m++) begin
          // fetch-to-flash may always start; any other path only while no general path is busy
          allow[m]     = is_fetch(s, m[MIDX_W-1:0]) || !gen;
          cand_c[s][m] = m_req[m] && tgt_c[m] == s[SIDX_W-1:0] && !owned[m] && allow[m];
        end
        if (|cand_c[s]) begin
          w          = pick(cand_c[s], last_q[s], prio_c);
          busy_d[s]  = 1'b1;
          owner_d[s] = w;
          last_d[s]  = w;
          owned[w]   = 1'b1;
          if (!is_fetch(s, w)) begin
            gen = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_q  <= '0;
      owner_q <= '0;
      last_q  <= '0;
    end else begin
      busy_q  <= busy_d;
      owner_q <= owner_d;
      last_q  <= last_d;
    end
  end

  // paths follow registered ownership; stalled masters see no ready
  always_comb begin
    m_gnt   = '0;
    m_ready = '0;
    m_rdata = '0;
    for (int s = 0; s < NUM_SLAVES; s++) begin
      s_sel[s]   = busy_q[s] && m_req[owner_q[s]];
      s_addr[s]  = busy_q[s] ? m_addr[owner_q[s]] : '0;
      s_we[s]    = busy_q[s] && m_we[owner_q[s]];
      s_wdata[s] = busy_q[s] ? m_wdata[owner_q[s]] : '0;
      if (busy_q[s]) begin
        m_gnt[owner_q[s]]   = 1'b1;
        m_ready[owner_q[s]] = s_ready[s] && m_req[owner_q[s]];
        m_rdata[owner_q[s]] = s_rdata[s];
      end
    end
  end

  logic [1:0] n_busy_c;
  logic [1:0] n_gen_c;
  always_comb begin
    n_busy_c = '0;
    n_gen_c  = '0;
    for (int s = 0; s < NUM_SLAVES; s++) begin
      n_busy_c = n_busy_c + {1'b0, busy_q[s]};
      n_gen_c  = n_gen_c + {1'b0, busy_q[s] && !is_fetch(s, owner_q[s])};
    end
  end

  property p_two_in_flight;
    @(posedge mclk) disable iff (rst) n_busy_c <= 2'h2 && n_gen_c <= 2'h1;
  endproperty
  a_two_in_flight: assert property (p_two_in_flight) else $error("too many transfers or general owners");

  property p_elev;
    @(posedge mclk) disable iff (rst)
      (m_elevate[M_DMA] |-> prio_c[M_DMA] == PRIO_ELEV) and
      (!m_elevate[M_DMA] |-> prio_c[M_DMA] == PRIO_FIXED[M_DMA]);
  endproperty
  a_elev: assert property (p_elev) else $error("dma priority not fixed or elevated as asked");

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLAVES; gs++) begin : g_chk
      property p_hold;
        @(posedge mclk) disable iff (rst)
          busy_q[gs] && !(s_ready[gs] && m_req[owner_q[gs]] && m_last[owner_q[gs]])
          |=> busy_q[gs] && $stable(owner_q[gs]);
      endproperty
      a_hold: assert property (p_hold) else $error("ownership changed mid-transaction");

      property p_release;
        @(posedge mclk) disable iff (rst)
          busy_q[gs] && s_ready[gs] && m_req[owner_q[gs]] && m_last[owner_q[gs]] |=> !busy_q[gs];
      endproperty
      a_release: assert property (p_release) else $error("slave not released after last beat");

      property p_win_prio;
        @(posedge mclk) disable iff (rst)
          !busy_q[gs] && |cand_c[gs] |->
            busy_d[gs] && cand_c[gs][owner_d[gs]] &&
            !(cand_c[gs][0] && prio_c[0] > prio_c[owner_d[gs]]) &&
            !(cand_c[gs][1] && prio_c[1] > prio_c[owner_d[gs]]) &&
            !(cand_c[gs][2] && prio_c[2] > prio_c[owner_d[gs]]) &&
            !(cand_c[gs][3] && prio_c[3] > prio_c[owner_d[gs]]);
      endproperty
      a_win_prio: assert property (p_win_prio) else $error("lower priority master won");

      property p_rr;
        @(posedge mclk) disable iff (rst)
          !busy_q[gs] && |cand_c[gs] |=> busy_q[gs] ##0 last_q[gs] == owner_q[gs];
      endproperty
      a_rr: assert property (p_rr) else $error("last winner not recorded");

      property p_route;
        @(posedge mclk) disable iff (rst)
          busy_q[gs] |-> s_addr[gs] == m_addr[owner_q[gs]] && s_wdata[gs] == m_wdata[owner_q[gs]]
                         && m_rdata[owner_q[gs]] == s_rdata[gs];
      endproperty
      a_route: assert property (p_route) else $error("path not routed to owner");
    end
  endgenerate

  genvar gm;
  generate
    for (gm = 0; gm < NUM_MASTERS; gm++) begin : g_mchk
      property p_stall;
        @(posedge mclk) disable iff (rst) m_req[gm] && !m_gnt[gm] |-> !m_ready[gm];
      endproperty
      a_stall: assert property (p_stall) else $error("stalled master saw ready");
    end
  endgenerate

endmodule

// ==== dv/slave_stub.sv ====
/*
  Stand-in for the three slaves: each beat ends after wait_n cycles and
  reads return the address XOR A5A55A5A. Assumes the switch holds a beat until s_ready.
*/
`timescale 1ns/1ps
module slave_stub
  import multi_port_switch_pkg::*;
(
  input  wire logic                        mclk,    // system clock
  input  wire logic                        rst,     // async reset
  input  wire logic [NUM_SLAVES-1:0]       s_sel,   // beat active
  input  wire logic [NUM_SLAVES-1:0][31:0] s_addr,  // beat address
  input  wire logic [NUM_SLAVES-1:0][1:0]  wait_n,  // stall cycles
  output logic      [NUM_SLAVES-1:0]       s_ready, // beat done
  output logic      [NUM_SLAVES-1:0][31:0] s_rdata  // read data
);
  logic [NUM_SLAVES-1:0][1:0] cnt_q;
  logic [NUM_SLAVES-1:0][1:0] cnt_d;
  always_comb begin
    for (int s = 0; s < NUM_SLAVES; s++) begin
      s_ready[s] = s_sel[s] && cnt_q[s] == wait_n[s];
      cnt_d[s]   = (s_sel[s] && !s_ready[s]) ? cnt_q[s] + 2'h1 : 2'h0;
      // not ready: a moving pattern, never the value last read
      s_rdata[s] = s_ready[s] ? s_addr[s] ^ 32'hA5A55A5A : ~s_addr[s] ^ {30'h0, cnt_q[s]};
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
endmodule

// ==== dv/testbench.sv ====
/*
  Self-checking bench for the crossbar: winners checked against a reference
  model of arbitration. Assumes slave_stub stands at the slave side.
*/
`timescale 1ns/1ps
module testbench
  import multi_port_switch_pkg::*;
;
  logic             mclk = 1'b0;
  logic             rst;
  logic [3:0]       m_req, m_we, m_last, m_elevate, m_gnt, m_ready;
  logic [3:0][31:0] m_addr, m_wdata, m_rdata;
  logic [2:0]       s_sel, s_we, s_ready;
  logic [2:0][31:0] s_addr, s_wdata, s_rdata;
  logic [2:0][1:0]  wait_n;
  logic [31:0]      lfsr_q;
  int               n_mismatch, comparisons, cyc;
  int               last[3];

  multi_port_switch multi_port_switch_inst (.mclk(mclk), .rst(rst), .m_req(m_req), .m_addr(m_addr),
    .m_we(m_we), .m_wdata(m_wdata), .m_last(m_last), .m_elevate(m_elevate), .m_gnt(m_gnt),
    .m_ready(m_ready), .m_rdata(m_rdata), .s_sel(s_sel), .s_addr(s_addr), .s_we(s_we),
    .s_wdata(s_wdata), .s_ready(s_ready), .s_rdata(s_rdata));
  slave_stub slave_stub_inst (.mclk(mclk), .rst(rst), .s_sel(s_sel), .s_addr(s_addr),
    .wait_n(wait_n), .s_ready(s_ready), .s_rdata(s_rdata));

  always #12.5 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // highest priority pending on slave s, ties rotate from last winner
  function automatic int pick(input int s, input logic [3:0] pend, input logic [7:0] tg, input logic [3:0] el);
    int best, bp, p, m;
    best = -1;
    bp = 0;
    for (int k = 1; k <= 4; k++) begin
      m = (last[s] + k) % 4;
      p = el[m] ? 3 : int'(PRIO_FIXED[m]);
      if (pend[m] && int'(tg[2*m+:2]) == s && (best < 0 || p > bp)) begin
        best = m;
        bp = p;
      end
    end
    return best;
  endfunction

  // all masters in mask start together; tg holds each master's slave
  task automatic run(input logic [7:0] tg, input logic [3:0] mask, input logic [3:0] el, input int nb,
                     input int peak_exp);
    int         beats[4];
    int         s, peak, gen;
    logic [3:0] pend, seen, rdy;
    pend = mask;
    seen = 4'h0;
    rdy = 4'h0;
    peak = 0;
    @(negedge mclk);
    lfsr_q = lfsr(lfsr_q);
    wait_n = lfsr_q[5:0];
    m_elevate = el;
    for (int i = 0; i < 4; i++) begin
      beats[i] = mask[i] ? nb : 0;
      lfsr_q = lfsr(lfsr_q);
      m_addr[i] = {tg[2*i+:2] == S_FLASH ? 2'h0 : tg[2*i+:2] == S_SRAM ? 2'h1 : {1'b1, lfsr_q[31]},
                   lfsr_q[29:0]};
      m_we[i] = lfsr_q[30];
      m_wdata[i] = lfsr(lfsr_q);
    end
    do begin
      for (int i = 0; i < 4; i++) begin
        beats[i] -= int'(rdy[i]);
        m_req[i] = beats[i] > 0;
        m_last[i] = beats[i] == 1;
      end
      #1;
      rdy = m_ready;
      gen = 0;
      check("stall", rdy & ~m_gnt, 4'h0);
      for (int i = 0; i < 4; i++) begin
        s = int'(tg[2*i+:2]);
        if (m_gnt[i] && !seen[i]) begin
          check("winner", i, pick(s, pend, tg, el));
          last[s] = i;
          seen[i] = 1'b1;
          pend[i] = 1'b0;
        end
        if (m_gnt[i] && !(i == 0 && s == 0)) gen++;
        if (rdy[i] && m_we[i]) check("write data", s_wdata[s], m_wdata[i]);
        if (rdy[i] && !m_we[i]) check("read data", m_rdata[i], m_addr[i] ^ 32'hA5A55A5A);
        if (rdy[i]) check("slave address", s_addr[s], m_addr[i]);
        if (rdy[i]) check("slave write", s_we[s], m_we[i]);
      end
      if ($countones(m_gnt) > peak) peak = $countones(m_gnt);
      if (gen > 1) check("general owners", gen, 1);
      @(negedge mclk);
    end while (m_req != 4'h0);
    m_elevate = 4'h0;
    if (peak_exp > 0) check("concurrent", peak, peak_exp);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    rst = 1'b1;
    {m_req, m_we, m_last, m_elevate} = '0;
    m_addr = '0;
    m_wdata = '0;
    wait_n = '0;
    lfsr_q = 32'hCC23FEC3;
    last = '{0, 0, 0};
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check("reset idle", {m_gnt, m_ready, s_sel}, 32'h0);
    rst = 1'b0;
    for (int i = 0; i < 4; i++)
      for (int s = 0; s < 3; s++) run(8'(s << 2*i), 4'(1 << i), 4'h0, 1, 0);
    run(8'h14, 4'h6, 4'h0, 2, 0);
    run(8'hA0, 4'h4, 4'h0, 1, 0);
    run(8'hA0, 4'hC, 4'h0, 1, 0);
    run(8'h00, 4'hA, 4'h8, 1, 0);
    run(8'h00, 4'hA, 4'h0, 1, 0);
    run(8'h24, 4'h7, 4'h0, 3, 2);
    // fetch port away from flash counts as general: only one may run
    run(8'h09, 4'h3, 4'h0, 1, 1);
    run(8'h55, 4'hF, 4'h0, 2, 0);
    close_out();
  end
endmodule
